// >>> verilog/tta_pkg.sv
/*
 Constants for the timing trigger and acquisition block: register map,
 field positions, reset values and timing counts.
 Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
// Operation
// - One-shot mode acquires once per run, then stops.
// - Repeating mode rearms after each acquisition until stop or stop condition.
// - Trace mode is shared with the companion analyzer both ways.
// - Arming comes from run command, companion arm or external arm input.
// - Transitional capture writes the first sample, then a sample only when some channel changed.
// - Each transitional sample carries a time tag of elapsed sample ticks.
// - Transitional capture samples every 10 ns regardless of settings.
// - Ring memory before trigger keeps prestore data up to the trigger.
// - Glitch is flagged when a channel crosses twice within one sample interval.
// - Glitch detection resolves pulses of 5 ns or more.
// - Glitch capture uses 512 sample entries plus 512 glitch entries.
// - Glitch capture stores every sample at a rate between 20 Hz and 50 MHz.
// - Glitch capture enables a per-channel glitch trigger mask.
// - Pattern match is the AND of all channel pattern matches.
// - After pattern, trigger falls at the configured edge condition.
// - Duration qualifier compares pattern persistence, greater or less than.
// - Greater-than limit spans 30 ns to 10 ms.
// - Less-than limit spans 40 ns to 10 ms.
// - Out-of-range durations clamp to the nearest limit.
// - Less-than disables edge and glitch terms, triggers at pattern end.
// - Less-than also needs the pattern present at least 20 ns.
// - Edge and glitch terms are ORed, then ANDed with pattern.
// - Greater-than triggers on an edge after duration met, pattern still present.
`default_nettype none
package tta_pkg;
   localparam int CLK_NS           = 5;
   localparam int TICK_NS          = 10;
   localparam int TICK_CYC         = TICK_NS / CLK_NS;
   localparam int DUR_GT_MIN_NS    = 30;
   localparam int DUR_LT_MIN_NS    = 40;
   localparam int DUR_MAX_NS       = 10_000_000;
   localparam int DUR_FLOOR_NS     = 20;
   localparam int DUR_GT_MIN_TICKS = (DUR_GT_MIN_NS + TICK_NS - 1) / TICK_NS;
   localparam int DUR_LT_MIN_TICKS = (DUR_LT_MIN_NS + TICK_NS - 1) / TICK_NS;
   localparam int DUR_MAX_TICKS    = DUR_MAX_NS / TICK_NS;
   localparam int DUR_FLOOR_TICKS  = (DUR_FLOOR_NS + TICK_NS - 1) / TICK_NS;
   localparam int GLT_MIN_PER_NS   = 20;
   localparam int GLT_MAX_PER_NS   = 50_000_000;
   localparam int GLT_MIN_PER_CYC  = (GLT_MIN_PER_NS + CLK_NS - 1) / CLK_NS;
   localparam int GLT_MAX_PER_CYC  = GLT_MAX_PER_NS / CLK_NS;
   localparam int GLITCH_MIN_NS    = 5;
   localparam int GLITCH_RES_CYC   = GLITCH_MIN_NS / CLK_NS;
   localparam int MEM_DEPTH        = 1024;
   localparam int GLT_DEPTH        = 512;
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_DUR    = 12'h004;
   localparam logic [11:0] REG_PAT    = 12'h008;
   localparam logic [11:0] REG_CARE   = 12'h00C;
   localparam logic [11:0] REG_RISE   = 12'h010;
   localparam logic [11:0] REG_FALL   = 12'h014;
   localparam logic [11:0] REG_GMASK  = 12'h018;
   localparam logic [11:0] REG_RATE   = 12'h01C;
   localparam logic [11:0] REG_STATUS = 12'h020;
   localparam logic [11:0] REG_RDADDR = 12'h024;
   localparam logic [11:0] REG_MEMDAT = 12'h028;
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_STOP    = 1;
   localparam int CTRL_REP     = 2;
   localparam int CTRL_GLT     = 3;
   localparam int CTRL_ARM_LSB = 4;
   localparam int CTRL_LESS    = 6;
   localparam int CTRL_STOPEN  = 7;
   localparam logic [1:0] ARM_RUN  = 2'h0;
   localparam logic [1:0] ARM_COMP = 2'h1;
   localparam logic [1:0] ARM_EXT  = 2'h2;
   localparam logic [23:0] DUR_RESET  = 24'h000003;
   localparam logic [23:0] RATE_RESET = 24'h000004;
endpackage : tta_pkg
`default_nettype wire

// >>> verilog/tta_capture_mem.sv
/*
 Capture memory: one write port, one read port with registered read data.
 Assumes writer and reader share the system clock.
*/
`default_nettype none
module tta_capture_mem #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10,
   parameter int W     = 32
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset_n,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [W-1:0]  i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [W-1:0]  o_rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule : tta_capture_mem
`default_nettype wire

// >>> verilog/tta_core.sv
/*
 Timing analyzer acquisition and trigger core with APB register slave.
 Probe inputs are taken as synchronous to i_sys_clk; the companion
 analyzer exchanges arm and trace-mode signals on plain ports.
*/
`default_nettype none
module tta_core #(
   parameter int CH            = 16,
   parameter int POST_LEN      = 512,
   parameter int DUR_MAX_TICKS = tta_pkg::DUR_MAX_TICKS,
   parameter int GLT_MAX_CYC   = tta_pkg::GLT_MAX_PER_CYC
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset_n,
   input  wire logic          i_psel,
   input  wire logic          i_penable,
   input  wire logic          i_pwrite,
   input  wire logic [11:0]   i_paddr,
   input  wire logic [31:0]   i_pwdata,
   output logic      [31:0]   o_prdata,
   output logic               o_pready,
   output logic               o_pslverr,
   input  wire logic [CH-1:0] i_probe,
   input  wire logic          i_companion_arm,
   input  wire logic          i_external_arm_input,
   input  wire logic          i_stop_meas,
   input  wire logic          i_companion_mode_set,
   input  wire logic          i_companion_repetitive,
   output logic               o_trace_mode_set,
   output logic               o_trace_repetitive,
   output logic               o_trigger
);
   localparam int TAG_W = 32 - CH;
   localparam logic [23:0] DMAX = 24'(DUR_MAX_TICKS);
   localparam logic [23:0] GMAX = 24'(GLT_MAX_CYC);

   typedef enum logic [2:0] {ST_IDLE, ST_WAIT_ARM, ST_PRE, ST_POST, ST_DONE} tta_state_e;

   typedef struct packed {
      tta_state_e         st;
      logic               rep;
      logic               glt;
      logic [1:0]         arm_sel;
      logic               less;
      logic               stop_en;
      logic [CH-1:0]      pat;
      logic [CH-1:0]      care;
      logic [CH-1:0]      rise;
      logic [CH-1:0]      fall;
      logic [CH-1:0]      gmask;
      logic [23:0]        dur;
      logic [23:0]        rate;
      logic [9:0]         rd_addr;
      logic [31:0]        prdata;
      logic               ack;
      logic               done;
      logic               triggered;
      logic [9:0]         trig_addr;
      logic               tdiv;
      logic [23:0]        gdiv;
      logic [CH-1:0]      p1;
      logic [CH-1:0]      prev;
      logic [CH-1:0]      smp;
      logic [CH-1:0]      once;
      logic [CH-1:0]      gacc;
      logic [CH-1:0]      gflag;
      logic               gpend;
      logic [TAG_W-1:0]   tag;
      logic               first;
      logic [9:0]         wr_addr;
      logic [10:0]        post_cnt;
      logic [23:0]        dcnt;
      logic               match_q;
      logic               mode_set;
      logic               trig_pulse;
   } tta_core_s;

   tta_core_s s;
   tta_core_s n;

   logic [31:0]   mem_rdata;
   logic          mem_we;
   logic [9:0]    mem_waddr;
   logic [31:0]   mem_wdata;
   logic [CH-1:0] tr;
   logic [CH-1:0] once_nx;
   logic [CH-1:0] gacc_nx;
   logic [CH-1:0] glt_now;

   // Glitch: a second crossing inside the same sample interval
   for (genvar g = 0; g < CH; g++) begin : g_glitch
      assign tr[g]      = i_probe[g] ^ s.p1[g];
      assign glt_now[g] = s.gacc[g] | (s.once[g] & tr[g]);
      assign once_nx[g] = s.once[g] | tr[g];
      assign gacc_nx[g] = glt_now[g];
   end

   logic        tick;
   logic        gtick;
   logic        stick;
   logic        match;
   logic [23:0] dur_eff;
   logic [23:0] rate_eff;
   logic [23:0] dur_min;
   logic [CH-1:0] edges;
   logic        gterm;
   logic        any_term;
   logic        gt_fire;
   logic        lt_fire;
   logic        trig_fire;
   logic        arm_ok;
   logic        acc_end;
   logic        mapped;
   logic [31:0] rmux;
   logic        store;
   logic [TAG_W-1:0] elapsed;
   logic [9:0]  wrap;

   always_comb begin
      n = s;
      n.mode_set   = 1'b0;
      n.trig_pulse = 1'b0;
      n.p1         = i_probe;
      mem_we       = 1'b0;
      mem_waddr    = s.wr_addr;
      mem_wdata    = '0;
      // Trigger logic runs on the fixed 10 ns tick in both capture modes
      tick  = s.tdiv;
      n.tdiv = ~s.tdiv;
      rate_eff = (s.rate < 24'(tta_pkg::GLT_MIN_PER_CYC)) ? 24'(tta_pkg::GLT_MIN_PER_CYC) :
                 (s.rate > GMAX) ? GMAX : s.rate;
      gtick = (s.gdiv >= rate_eff - 24'h000001);
      n.gdiv = gtick ? 24'h000000 : s.gdiv + 24'h000001;
      stick = s.glt ? gtick : tick;
      n.once = stick ? '0 : once_nx;
      n.gacc = stick ? '0 : gacc_nx;
      dur_min = s.less ? 24'(tta_pkg::DUR_LT_MIN_TICKS) : 24'(tta_pkg::DUR_GT_MIN_TICKS);
      dur_eff = (s.dur < dur_min) ? dur_min : (s.dur > DMAX) ? DMAX : s.dur;
      match = &(~((i_probe ^ s.pat) & s.care));
      edges = (s.rise & ~s.prev & i_probe) | (s.fall & s.prev & ~i_probe);
      gterm = s.glt & (|(s.gmask & glt_now));
      any_term = (|(s.rise | s.fall)) | (s.glt & (|s.gmask));
      gt_fire = match & (s.dcnt >= dur_eff) & (!any_term | (|edges) | gterm);
      lt_fire = s.match_q & ~match & (s.dcnt >= 24'(tta_pkg::DUR_FLOOR_TICKS))
                & (s.dcnt < dur_eff);
      trig_fire = tick & (s.st == ST_PRE) & (s.less ? lt_fire : gt_fire);
      if (tick) begin
         n.prev    = i_probe;
         n.match_q = match;
         n.dcnt    = !match ? 24'h000000 : (s.dcnt == DMAX) ? s.dcnt : s.dcnt + 24'h000001;
      end
      // Storage into the ring; pretrigger data is simply the ring contents
      wrap    = s.glt ? 10'(tta_pkg::GLT_DEPTH - 1) : 10'(tta_pkg::MEM_DEPTH - 1);
      elapsed = (&s.tag) ? s.tag : s.tag + 1'b1;
      store   = 1'b0;
      if (s.gpend) begin
         mem_we    = 1'b1;
         mem_waddr = s.wr_addr | 10'(tta_pkg::GLT_DEPTH);
         mem_wdata = 32'(s.gflag);
         n.gpend   = 1'b0;
         n.wr_addr = (s.wr_addr == wrap) ? 10'h000 : s.wr_addr + 10'h001;
      end else if (stick && (s.st == ST_PRE || s.st == ST_POST)) begin
         if (s.glt) begin
            store     = 1'b1;
            mem_we    = 1'b1;
            mem_wdata = 32'(i_probe);
            n.gflag   = glt_now;
            n.gpend   = 1'b1;
         end else begin
            n.tag = elapsed;
            if (s.first || i_probe != s.smp) begin
               store     = 1'b1;
               mem_we    = 1'b1;
               mem_wdata = {(s.first ? {TAG_W{1'b0}} : elapsed), i_probe};
               n.tag     = '0;
               n.wr_addr = (s.wr_addr == wrap) ? 10'h000 : s.wr_addr + 10'h001;
            end
         end
         if (store) begin
            n.smp   = i_probe;
            n.first = 1'b0;
            if (s.st == ST_POST) begin
               n.post_cnt = s.post_cnt + 11'h001;
            end
         end
      end
      arm_ok = (s.arm_sel == tta_pkg::ARM_COMP) ? i_companion_arm :
               (s.arm_sel == tta_pkg::ARM_EXT) ? i_external_arm_input : 1'b1;
      case (s.st)
         ST_IDLE: begin
         end
         ST_WAIT_ARM: begin
            if (arm_ok) begin
               n.st        = ST_PRE;
               n.wr_addr   = 10'h000;
               n.first     = 1'b1;
               n.triggered = 1'b0;
               n.post_cnt  = '0;
               n.gpend     = 1'b0;
            end
         end
         ST_PRE: begin
            if (trig_fire) begin
               n.st         = ST_POST;
               n.triggered  = 1'b1;
               n.trig_addr  = s.wr_addr;
               n.trig_pulse = 1'b1;
            end
         end
         ST_POST: begin
            if (s.post_cnt >= (s.glt ? 11'(POST_LEN / 2) : 11'(POST_LEN)) && !s.gpend) begin
               n.st = ST_DONE;
            end
         end
         ST_DONE: begin
            n.done = 1'b1;
            if (s.rep && !(s.stop_en && i_stop_meas)) begin
               n.st = ST_WAIT_ARM;
            end else begin
               n.st = ST_IDLE;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      // Companion changed trace mode; a local write this cycle wins
      if (i_companion_mode_set) begin
         n.rep = i_companion_repetitive;
      end
      // APB: one wait cycle so memory read data are registered before pready
      mapped = (i_paddr[11:2] <= tta_pkg::REG_MEMDAT[11:2]) && (i_paddr[1:0] == 2'h0);
      case (i_paddr)
         tta_pkg::REG_CTRL:   rmux = 32'({s.stop_en, s.less, s.arm_sel, s.glt, s.rep, 2'h0});
         tta_pkg::REG_DUR:    rmux = 32'(dur_eff);
         tta_pkg::REG_PAT:    rmux = 32'(s.pat);
         tta_pkg::REG_CARE:   rmux = 32'(s.care);
         tta_pkg::REG_RISE:   rmux = 32'(s.rise);
         tta_pkg::REG_FALL:   rmux = 32'(s.fall);
         tta_pkg::REG_GMASK:  rmux = 32'(s.gmask);
         tta_pkg::REG_RATE:   rmux = 32'(rate_eff);
         tta_pkg::REG_STATUS: rmux = {6'h00, s.trig_addr, 2'h0, s.wr_addr,
                                      (s.st == ST_PRE || s.st == ST_POST), s.done, s.triggered,
                                      (s.st != ST_IDLE)};
         tta_pkg::REG_RDADDR: rmux = 32'(s.rd_addr);
         tta_pkg::REG_MEMDAT: rmux = mem_rdata;
         default:             rmux = 32'h00000000;
      endcase
      acc_end = i_psel & i_penable & s.ack;
      if (i_psel && i_penable && !s.ack) begin
         n.ack    = 1'b1;
         n.prdata = i_pwrite ? 32'h00000000 : rmux;
      end else if (acc_end) begin
         n.ack = 1'b0;
         if (!i_pwrite && i_paddr == tta_pkg::REG_MEMDAT) begin
            n.rd_addr = s.rd_addr + 10'h001;
         end
         if (i_pwrite) begin
            case (i_paddr)
               tta_pkg::REG_CTRL: begin
                  n.rep      = i_pwdata[tta_pkg::CTRL_REP];
                  n.mode_set = 1'b1;
                  n.glt      = i_pwdata[tta_pkg::CTRL_GLT];
                  n.arm_sel  = i_pwdata[tta_pkg::CTRL_ARM_LSB +: 2];
                  n.less     = i_pwdata[tta_pkg::CTRL_LESS];
                  n.stop_en  = i_pwdata[tta_pkg::CTRL_STOPEN];
                  if (i_pwdata[tta_pkg::CTRL_STOP]) begin
                     n.st = ST_IDLE;
                  end else if (i_pwdata[tta_pkg::CTRL_RUN]) begin
                     n.st   = ST_WAIT_ARM;
                     n.done = 1'b0;
                  end
               end
               tta_pkg::REG_DUR:    n.dur     = i_pwdata[23:0];
               tta_pkg::REG_PAT:    n.pat     = i_pwdata[CH-1:0];
               tta_pkg::REG_CARE:   n.care    = i_pwdata[CH-1:0];
               tta_pkg::REG_RISE:   n.rise    = i_pwdata[CH-1:0];
               tta_pkg::REG_FALL:   n.fall    = i_pwdata[CH-1:0];
               tta_pkg::REG_GMASK:  n.gmask   = i_pwdata[CH-1:0];
               tta_pkg::REG_RATE:   n.rate    = i_pwdata[23:0];
               tta_pkg::REG_RDADDR: n.rd_addr = i_pwdata[9:0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s      <= '0;
         s.st   <= ST_IDLE;
         s.dur  <= tta_pkg::DUR_RESET;
         s.rate <= tta_pkg::RATE_RESET;
      end else begin
         s <= n;
      end
   end

   tta_capture_mem #(
      .DEPTH (tta_pkg::MEM_DEPTH),
      .AW    (10),
      .W     (32)
   ) u_mem (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_we      (mem_we),
      .i_waddr   (mem_waddr),
      .i_wdata   (mem_wdata),
      .i_raddr   (s.rd_addr),
      .o_rdata   (mem_rdata)
   );

   assign o_prdata           = s.prdata;
   assign o_pready           = i_psel & i_penable & s.ack;
   assign o_pslverr          = o_pready & ~mapped;
   assign o_trace_mode_set   = s.mode_set;
   assign o_trace_repetitive = s.rep;
   assign o_trigger          = s.trig_pulse;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   one_shot_a: assert property (s.st == ST_DONE && !s.rep |=> s.st == ST_IDLE)
      else $error("single trace did not stop");
   rep_rearm_a: assert property (s.st == ST_DONE && s.rep && !(s.stop_en && i_stop_meas)
                                 |=> s.st == ST_WAIT_ARM)
      else $error("repetitive trace did not rearm");
   ext_arm_a: assert property (s.st == ST_WAIT_ARM && s.arm_sel == tta_pkg::ARM_EXT
                               && !i_external_arm_input |=> s.st == ST_WAIT_ARM)
      else $error("armed without external arm");
   trans_store_a: assert property (mem_we && !s.glt && !s.first && !s.gpend
                                   |-> mem_wdata[CH-1:0] != s.smp)
      else $error("unchanged sample stored");
   tick_rate_a: assert property (tick |=> !tick ##1 tick)
      else $error("sample tick not every 10 ns");
   glitch_pair_a: assert property (mem_we && s.glt && !s.gpend
                                   |=> mem_we && mem_waddr[9] && mem_waddr[8:0] == $past(mem_waddr[8:0]))
      else $error("glitch half not written after sample");
   pat_and_a: assert property (trig_fire && !s.less |-> match)
      else $error("trigger without full pattern");
   gt_dur_a: assert property (trig_fire && !s.less |-> s.dcnt >= dur_eff && dur_eff >= 24'h000003)
      else $error("greater-than trigger before duration");
   lt_end_a: assert property (trig_fire && s.less |-> !match && $past(match, 2) && s.dcnt >= 24'h000002)
      else $error("less-than trigger not at pattern end");
   clamp_a: assert property (dur_eff <= DMAX && dur_eff >= (s.less ? 24'h000004 : 24'h000003))
      else $error("duration outside clamp limits");
   dur_clear_a: assert property (tick && !match |=> s.dcnt == 24'h000000)
      else $error("duration count not cleared");
endmodule : tta_core
`default_nettype wire

// >>> sim/tta_probe_src.sv
/*
 Probe source standing in for the probed target system.
 Assumes the core samples the probes on the same system clock.
*/
`default_nettype none
module tta_probe_src (
   input  wire logic        i_sys_clk,
   input  wire logic [15:0] i_level,
   input  wire logic        i_busy_bus,
   output logic      [15:0] o_probe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial o_probe = 16'h0000;
   // Counting bus differs at every sample tick, so every tick is a transition
   always @(posedge i_sys_clk) begin
      if (i_busy_bus)
         o_probe <= o_probe + 16'h0001;
      else
         o_probe <= i_level;
   end
endmodule : tta_probe_src
`default_nettype wire

// >>> sim/tb_timing_trigger_acquisition.sv
/*
 Self-checking bench for the timing trigger core: registers over APB,
 trace-mode sharing, arming sources, pattern trigger and single runs.
 Assumes the core answers APB with its own wait states.
*/
`default_nettype none
module tb_timing_trigger_acquisition;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DMAX = 50;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, trig, mset, mrep;
   logic [15:0] level = 16'h0000;
   logic [15:0] probe, pat;
   logic        busy_bus = 1'b0;
   logic        c_arm = 1'b0;
   logic        x_arm = 1'b0;
   logic        c_set = 1'b0;
   logic        c_rep = 1'b0;
   int          seed = 96;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          seen_trig = 0;
   int          dvals[3] = '{0, 7, 32'h00FFFFFF};
   int          lt_len[3] = '{1, 10, 3};
   int          lt_exp[3] = '{0, 0, 1};
   int          seen_mset = 0;
   int          m0 = 0;
   logic        stop_m = 1'b0;
   logic [15:0] v;

   always #2.5 clk = ~clk;

   tta_probe_src src (.i_sys_clk(clk), .i_level(level), .i_busy_bus(busy_bus), .o_probe(probe));

   tta_core #(.CH(16), .POST_LEN(8), .DUR_MAX_TICKS(DMAX), .GLT_MAX_CYC(64)) dut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_probe(probe), .i_companion_arm(c_arm), .i_external_arm_input(x_arm), .i_stop_meas(stop_m),
      .i_companion_mode_set(c_set), .i_companion_repetitive(c_rep), .o_trace_mode_set(mset),
      .o_trace_repetitive(mrep), .o_trigger(trig));

   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cycles++;
      if (trig === 1'b1)
         seen_trig++;
      if (mset === 1'b1)
         seen_mset++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // Request stands until pready is seen high at a rising edge; answer taken there
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(rd, exp, what);
   endtask : rdchk

   task trig_chk(input int cyc, input int exp, input string what);
      repeat (cyc) @(posedge clk);
      check(32'(seen_trig), 32'(exp), what);
      seen_trig = 0;
   endtask : trig_chk

   function automatic logic [31:0] clamp(input int v, input bit lt);
      int lo;
      lo = lt ? tta_pkg::DUR_LT_MIN_TICKS : tta_pkg::DUR_GT_MIN_TICKS;
      return 32'((v < lo) ? lo : (v > DMAX) ? DMAX : v);
   endfunction : clamp

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(tta_pkg::REG_DUR, 32'(tta_pkg::DUR_RESET), "dur reset");
      rdchk(tta_pkg::REG_RATE, 32'(tta_pkg::RATE_RESET), "rate reset");
      rdchk(tta_pkg::REG_CTRL, 32'h0, "ctrl reset");
      apb(1'b0, 12'h02C, 32'h0);
      check(32'(err), 32'h1, "unmapped error");
      for (int lt = 0; lt < 2; lt++) begin
         apb(1'b1, tta_pkg::REG_CTRL, 32'(lt) << tta_pkg::CTRL_LESS);
         foreach (dvals[i]) begin
            apb(1'b1, tta_pkg::REG_DUR, dvals[i]);
            rdchk(tta_pkg::REG_DUR, clamp(dvals[i], lt[0]), "dur clamp");
         end
      end
      m0 = seen_mset;
      apb(1'b1, tta_pkg::REG_CTRL, 32'h1 << tta_pkg::CTRL_REP);
      repeat (2) @(posedge clk);
      check(32'(mrep), 32'h1, "mode out");
      c_set <= 1'b1;
      @(posedge clk);
      c_set <= 1'b0;
      repeat (2) @(posedge clk);
      check(32'(mrep), 32'h0, "mode in");
      check(32'(seen_mset - m0), 32'h1, "mode pulse");
      for (int s = 0; s < 3; s++) begin
         pat = 16'($random(seed));
         apb(1'b1, tta_pkg::REG_PAT, 32'(pat));
         apb(1'b1, tta_pkg::REG_CARE, 32'h0000FFFF);
         apb(1'b1, tta_pkg::REG_DUR, 32'h3);
         // Run source sees a near miss, the others a match but no arm
         level <= (s == 0) ? pat ^ 16'h0001 : pat;
         apb(1'b1, tta_pkg::REG_CTRL, (32'(s) << tta_pkg::CTRL_ARM_LSB) | 32'h1);
         seen_trig = 0;
         repeat (30) @(posedge clk);
         check(32'(seen_trig), 32'h0, "early trigger");
         level <= pat;
         c_arm <= (s == 1);
         x_arm <= (s == 2);
         repeat (40) @(posedge clk);
         check(32'(seen_trig), 32'h1, "trigger");
         busy_bus <= 1'b1;
         repeat (40) @(posedge clk);
         apb(1'b0, tta_pkg::REG_STATUS, 32'h0);
         check({31'h0, rd[2]}, 32'h1, "done");
         check({31'h0, rd[0]}, 32'h0, "idle");
         check(32'(seen_trig), 32'h1, "one shot");
         busy_bus <= 1'b0;
         c_arm <= 1'b0;
         x_arm <= 1'b0;
      end
      // Edge term must follow a met duration with the pattern still there
      seen_trig = 0;
      apb(1'b1, tta_pkg::REG_CARE, 32'h0000FFFE);
      apb(1'b1, tta_pkg::REG_RISE, 32'h00000001);
      level <= pat & 16'hFFFE;
      apb(1'b1, tta_pkg::REG_CTRL, 32'h1);
      trig_chk(30, 0, "no edge");
      level <= pat | 16'h0001;
      trig_chk(20, 1, "edge trigger");
      // Less-than: edges ignored, fires only after 2 to DUR-1 ticks of pattern
      apb(1'b1, tta_pkg::REG_CARE, 32'h0000FFFF);
      apb(1'b1, tta_pkg::REG_DUR, 32'h5);
      level <= ~pat;
      apb(1'b1, tta_pkg::REG_CTRL, (32'h1 << tta_pkg::CTRL_LESS) | 32'h1);
      foreach (lt_len[i]) begin
         level <= pat;
         repeat (lt_len[i] * tta_pkg::TICK_CYC) @(posedge clk);
         level <= ~pat;
         trig_chk(12, lt_exp[i], "less-than");
      end
      // Transitional store: only changes, each with its tick count
      apb(1'b1, tta_pkg::REG_CARE, 32'h0);
      apb(1'b1, tta_pkg::REG_RISE, 32'h0);
      apb(1'b1, tta_pkg::REG_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      level <= pat;
      repeat (10) @(posedge clk);
      v = 16'($random(seed)) | 16'h0001;
      level <= pat ^ v;
      repeat (10) @(posedge clk);
      apb(1'b0, tta_pkg::REG_STATUS, 32'h0);
      check(32'(rd[13:4]), 32'h3, "store count");
      apb(1'b1, tta_pkg::REG_RDADDR, 32'h1);
      apb(1'b0, tta_pkg::REG_MEMDAT, 32'h0);
      check({16'h0000, rd[15:0]}, 32'(pat), "changed sample");
      rdchk(tta_pkg::REG_MEMDAT, {16'(10 / tta_pkg::TICK_CYC), pat ^ v}, "time tag");
      // Repeating runs rearm until the stop condition is met
      busy_bus <= 1'b1;
      apb(1'b1, tta_pkg::REG_CTRL, (32'h1 << tta_pkg::CTRL_REP) | (32'h1 << tta_pkg::CTRL_STOPEN) | 32'h1);
      seen_trig = 0;
      repeat (100) @(posedge clk);
      check(32'(seen_trig > 2), 32'h1, "rearm");
      stop_m <= 1'b1;
      repeat (40) @(posedge clk);
      apb(1'b0, tta_pkg::REG_STATUS, 32'h0);
      check({31'h0, rd[0]}, 32'h0, "stop condition");
      stop_m <= 1'b0;
      busy_bus <= 1'b0;
      // Glitch: one crossing per interval is none, a 5 ns pulse is one
      level <= pat;
      apb(1'b1, tta_pkg::REG_GMASK, 32'h1);
      apb(1'b1, tta_pkg::REG_RATE, 32'h1);
      rdchk(tta_pkg::REG_RATE, 32'(tta_pkg::GLT_MIN_PER_CYC), "rate clamp");
      apb(1'b1, tta_pkg::REG_RATE, 32'h8);
      apb(1'b1, tta_pkg::REG_CTRL, (32'h1 << tta_pkg::CTRL_GLT) | 32'h1);
      seen_trig = 0;
      level <= pat ^ 16'h0001;
      trig_chk(30, 0, "single edge");
      // Two pulses so one cannot straddle an interval boundary
      repeat (2) begin
         level <= pat;
         @(posedge clk);
         level <= pat ^ 16'h0001;
         repeat (3) @(posedge clk);
      end
      trig_chk(30, 1, "glitch trigger");
      wrap_up();
   end
endmodule : tb_timing_trigger_acquisition
`default_nettype wire
